// *** src/ccp_pwm_consts.vh ***
// Purpose: constants for the compare channel pwm block
// Assumes: word-indexed register port, 16-bit data, 25 MHz instruction clock
// Notes: register reset values are zero; the pin enable and the fault synchroniser reset high
`ifndef CCP_PWM_CONSTS_VH
`define CCP_PWM_CONSTS_VH

`define CCP_AW 4
`define CCP_DW 16

// register indices on the plain register port
`define CCP_ADDR_CTRL 4'h0
`define CCP_ADDR_MAIN 4'h1
`define CCP_ADDR_SEC 4'h2
`define CCP_ADDR_TA_CON 4'h3
`define CCP_ADDR_TA_PER 4'h4
`define CCP_ADDR_TA_CNT 4'h5
`define CCP_ADDR_TB_CON 4'h6
`define CCP_ADDR_TB_PER 4'h7
`define CCP_ADDR_TB_CNT 4'h8
`define CCP_ADDR_IFLG 4'h9
`define CCP_ADDR_IEN 4'hA

// channel control register fields
`define CCP_CTRL_MODE_HI 2
`define CCP_CTRL_TSEL 3
`define CCP_CTRL_FAULT 4
`define CCP_CTRL_SIDL 13

// timer control register fields
`define CCP_TCON_ON 15
`define CCP_TCON_SIDL 13
`define CCP_TCON_PS_HI 5
`define CCP_TCON_PS_LO 4

// interrupt flag / enable bit positions
`define CCP_IRQ_CMP 0
`define CCP_IRQ_TA 1
`define CCP_IRQ_TB 2

// channel modes
`define CCP_MODE_OFF 3'h0
`define CCP_MODE_LOW 3'h1
`define CCP_MODE_HIGH 3'h2
`define CCP_MODE_TOGGLE 3'h3
`define CCP_MODE_SINGLE 3'h4
`define CCP_MODE_CONT 3'h5
`define CCP_MODE_PWM 3'h6
`define CCP_MODE_PWM_FLT 3'h7

// timing: one timer increment per prescale count of instruction cycles, four oscillator periods each
`define CCP_OSC_PER_INSTR 4
`define CCP_CLK_NS 40

`define CCP_RST_WORD 16'h0000
`define CCP_DUTY_ZERO 16'h0000

`endif

// *** src/ccp_pwm_channel.v ***
// Purpose: one output compare channel with simple pwm, fault trip and two time bases
// Assumes: mclk_in is the instruction clock; sleep/idle come from the same clock domain
// Notes: read data appear the cycle after the read strobe; unmapped reads give zero
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "ccp_pwm_consts.vh"

// Behaviour
// - mode 110 or 111 selects pwm; 111 also arms fault protection.
// - in pwm the main duty latch ignores software writes; secondary latch takes them.
// - in mode 111 a low fault input releases the output pin.
// - a fault trip sets the fault flag at control bit 4.
// - tripped state lasts until fault input is high and a pwm mode is rewritten.
// - period is (period register + 1) times prescale instruction cycles.
// - on the increment after count equals period, clear count and set pin.
// - at that rollover the secondary duty moves into the main duty latch.
// - at that rollover the selected timer's interrupt flag is set.
// - a latched duty of zero keeps the pin low all period.
// - a duty above the period keeps the pin high all period.
// - during sleep the pin holds its level from before sleep.
// - after wake the channel carries on from its retained state.
// - in idle the channel runs only if neither it nor its timer stops.
// - compare events in modes 001 to 101 set the compare flag; request needs its enable.
// - interrupt flags stay set until software clears them.
// - pwm never sets the compare flag; it uses the timer flag only.
// - timer select bit 3 picks time base b; clear picks time base a.
module ccp_pwm_channel (
  input wire mclk_in,
  input wire nrst_in,
  input wire [`CCP_AW-1:0] addr_in,
  input wire [`CCP_DW-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire sleep_in,
  input wire idle_in,
  input wire fault_n_in,
  output reg [`CCP_DW-1:0] rdata_out,
  output reg pin_out,
  output reg pin_oe_out,
  output reg irq_out
);

  reg [15:0] ctrl_ff;
  reg [15:0] main_ff;
  reg [15:0] sec_ff;
  reg [15:0] tcon_ff [0:1];
  reg [15:0] tper_ff [0:1];
  reg [15:0] tcnt_ff [0:1];
  reg [7:0] pscnt_ff [0:1];
  reg [2:0] iflg_ff;
  reg [2:0] ien_ff;
  reg flt_s1_ff;
  reg flt_s2_ff;
  reg rearm_ff;
  reg [2:0] nxt_iflg;
  reg [15:0] nxt_rdata;
  integer i;

  // prescale 1, 8, 64, 256 as a terminal count
  function [7:0] ps_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ps_limit = 8'h00;
        2'h1: ps_limit = 8'h07;
        2'h2: ps_limit = 8'h3F;
        default: ps_limit = 8'hFF;
      endcase
    end
  endfunction

  // register index of field k of time base t
  function [3:0] t_addr;
    input t;
    input [1:0] k;
    begin
      t_addr = t ? (`CCP_ADDR_TB_CON + {2'h0, k}) : (`CCP_ADDR_TA_CON + {2'h0, k});
    end
  endfunction

  // either pwm mode; serves the live mode and a mode being written
  function is_pwm;
    input [2:0] m;
    begin
      is_pwm = (m == `CCP_MODE_PWM) || (m == `CCP_MODE_PWM_FLT);
    end
  endfunction

  wire [2:0] mode = ctrl_ff[`CCP_CTRL_MODE_HI:0];
  wire pwm_mode = is_pwm(mode);
  wire tsel = ctrl_ff[`CCP_CTRL_TSEL];
  wire fault_flag = ctrl_ff[`CCP_CTRL_FAULT];

  // time base run: on, not asleep, not stopped by idle
  wire [1:0] t_run;
  wire [1:0] t_tick;
  wire [1:0] t_roll;
  assign t_run[0] = tcon_ff[0][`CCP_TCON_ON] && !sleep_in
                    && !(idle_in && tcon_ff[0][`CCP_TCON_SIDL]);
  assign t_run[1] = tcon_ff[1][`CCP_TCON_ON] && !sleep_in
                    && !(idle_in && tcon_ff[1][`CCP_TCON_SIDL]);
  // one increment per prescale count of instruction cycles
  assign t_tick[0] = t_run[0]
    && (pscnt_ff[0] == ps_limit(tcon_ff[0][`CCP_TCON_PS_HI:`CCP_TCON_PS_LO]));
  assign t_tick[1] = t_run[1]
    && (pscnt_ff[1] == ps_limit(tcon_ff[1][`CCP_TCON_PS_HI:`CCP_TCON_PS_LO]));
  assign t_roll[0] = t_tick[0] && (tcnt_ff[0] == tper_ff[0]);
  assign t_roll[1] = t_tick[1] && (tcnt_ff[1] == tper_ff[1]);

  // selected time base
  wire s_tick = (tsel ? t_tick[1] : t_tick[0]);
  wire s_roll = (tsel ? t_roll[1] : t_roll[0]);
  wire [15:0] s_cnt = tsel ? tcnt_ff[1] : tcnt_ff[0];
  wire [15:0] s_next = s_roll ? 16'h0000 : s_cnt + 16'h0001;

  // channel stops in idle on its own bit or when its time base stops
  wire ch_run = !sleep_in && !(idle_in && ctrl_ff[`CCP_CTRL_SIDL]);
  wire ev_tick = ch_run && s_tick;
  wire ev_roll = ch_run && s_roll;
  wire ev_match = ev_tick && (s_next == main_ff);

  wire fault_now = (mode == `CCP_MODE_PWM_FLT) && !flt_s2_ff;
  wire ctrl_wr = wr_in && (addr_in == `CCP_ADDR_CTRL);

  // flags: hardware set wins over a software clear in the same cycle
  always @* begin
    nxt_iflg = iflg_ff;
    if (wr_in && addr_in == `CCP_ADDR_IFLG) begin
      nxt_iflg = iflg_ff & ~wdata_in[2:0];
    end
    if (ev_match && !pwm_mode && mode != `CCP_MODE_OFF) begin
      nxt_iflg[`CCP_IRQ_CMP] = 1'b1;
    end
    if (t_roll[0]) begin
      nxt_iflg[`CCP_IRQ_TA] = 1'b1;
    end
    if (t_roll[1]) begin
      nxt_iflg[`CCP_IRQ_TB] = 1'b1;
    end
  end

  always @* begin
    case (addr_in)
      `CCP_ADDR_CTRL: nxt_rdata = ctrl_ff;
      `CCP_ADDR_MAIN: nxt_rdata = main_ff;
      `CCP_ADDR_SEC: nxt_rdata = sec_ff;
      `CCP_ADDR_TA_CON: nxt_rdata = tcon_ff[0];
      `CCP_ADDR_TA_PER: nxt_rdata = tper_ff[0];
      `CCP_ADDR_TA_CNT: nxt_rdata = tcnt_ff[0];
      `CCP_ADDR_TB_CON: nxt_rdata = tcon_ff[1];
      `CCP_ADDR_TB_PER: nxt_rdata = tper_ff[1];
      `CCP_ADDR_TB_CNT: nxt_rdata = tcnt_ff[1];
      `CCP_ADDR_IFLG: nxt_rdata = {13'h0000, iflg_ff};
      `CCP_ADDR_IEN: nxt_rdata = {13'h0000, ien_ff};
      default: nxt_rdata = `CCP_RST_WORD;
    endcase
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      flt_s1_ff <= 1'b1;
      flt_s2_ff <= 1'b1;
    end else begin
      flt_s1_ff <= fault_n_in;
      flt_s2_ff <= flt_s1_ff;
    end
  end

  // time bases
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      for (i = 0; i < 2; i = i + 1) begin
        tcon_ff[i] <= `CCP_RST_WORD;
        tper_ff[i] <= `CCP_RST_WORD;
        tcnt_ff[i] <= `CCP_RST_WORD;
        pscnt_ff[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (t_tick[i]) begin
          pscnt_ff[i] <= 8'h00;
        end else if (t_run[i]) begin
          pscnt_ff[i] <= pscnt_ff[i] + 8'h01;
        end
        if (wr_in && addr_in == t_addr(i[0], 2'h2)) begin
          tcnt_ff[i] <= wdata_in;
        end else if (t_roll[i]) begin
          tcnt_ff[i] <= 16'h0000;
        end else if (t_tick[i]) begin
          tcnt_ff[i] <= tcnt_ff[i] + 16'h0001;
        end
        if (wr_in && addr_in == t_addr(i[0], 2'h0)) begin
          tcon_ff[i] <= wdata_in;
          pscnt_ff[i] <= 8'h00;
        end
        if (wr_in && addr_in == t_addr(i[0], 2'h1)) begin
          tper_ff[i] <= wdata_in;
        end
      end
    end
  end

  // channel, registers and pin
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      ctrl_ff <= `CCP_RST_WORD;
      main_ff <= `CCP_RST_WORD;
      sec_ff <= `CCP_RST_WORD;
      iflg_ff <= 3'h0;
      ien_ff <= 3'h0;
      rearm_ff <= 1'b0;
      rdata_out <= `CCP_RST_WORD;
      pin_out <= 1'b0;
      pin_oe_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      iflg_ff <= nxt_iflg;
      irq_out <= |(nxt_iflg & ien_ff);
      if (rd_in) begin
        rdata_out <= nxt_rdata;
      end
      if (wr_in && addr_in == `CCP_ADDR_IEN) begin
        ien_ff <= wdata_in[2:0];
      end
      if (wr_in && addr_in == `CCP_ADDR_SEC) begin
        sec_ff <= wdata_in;
      end
      // main duty is read-only while in pwm so a period never glitches
      if (wr_in && addr_in == `CCP_ADDR_MAIN && !pwm_mode) begin
        main_ff <= wdata_in;
      end
      if (ctrl_wr) begin
        ctrl_ff[15:0] <= {2'h0, wdata_in[`CCP_CTRL_SIDL], 8'h00, ctrl_ff[`CCP_CTRL_FAULT],
                          wdata_in[`CCP_CTRL_TSEL:0]};
      end
      // fault trip; release needs both a high input and a mode rewrite
      if (fault_now) begin
        ctrl_ff[`CCP_CTRL_FAULT] <= 1'b1;
        rearm_ff <= 1'b0;
        pin_oe_out <= 1'b0;
      end else if (fault_flag) begin
        // the mode being written counts, not the one it replaces
        if (ctrl_wr && is_pwm(wdata_in[`CCP_CTRL_MODE_HI:0])) begin
          rearm_ff <= 1'b1;
        end
        if (rearm_ff && flt_s2_ff) begin
          ctrl_ff[`CCP_CTRL_FAULT] <= 1'b0;
          pin_oe_out <= 1'b1;
        end
      end else begin
        pin_oe_out <= 1'b1;
      end
      // pin only moves on channel events, so sleep simply holds it
      if (pwm_mode) begin
        if (ev_roll) begin
          main_ff <= sec_ff;
          pin_out <= (sec_ff != `CCP_DUTY_ZERO);
        end else if (ev_match) begin
          pin_out <= 1'b0;
        end
      end else if (ev_match) begin
        case (mode)
          `CCP_MODE_LOW: pin_out <= 1'b0;
          `CCP_MODE_HIGH: pin_out <= 1'b1;
          `CCP_MODE_TOGGLE: pin_out <= ~pin_out;
          default: pin_out <= pin_out;
        endcase
      end
    end
  end

endmodule

// *** test/ccp_pwm_props.sv ***
// Purpose: port-level checks for ccp_pwm_channel
// Assumes: one clock, synchronous active-low reset
// Notes: fault input reaches the logic two cycles late
`timescale 1ns/1ns
module ccp_pwm_props (
  input wire mclk_in,
  input wire nrst_in,
  input wire [3:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire sleep_in,
  input wire fault_n_in,
  input wire [15:0] rdata_out,
  input wire pin_out,
  input wire pin_oe_out,
  input wire irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_sleep_pin_hold: assert property (sleep_in |=> $stable(pin_out))
    else $error("pin moved during sleep");
  a_sleep_irq_hold: assert property (sleep_in && $past(sleep_in) && !wr_in && !$past(wr_in)
    |=> $stable(irq_out))
    else $error("irq moved during sleep");
  a_irq_flag_sticky: assert property (irq_out && !wr_in && !$past(wr_in) |=> irq_out)
    else $error("irq dropped without a write");
  a_trip_cause: assert property ($fell(pin_oe_out) |->
    !$past(fault_n_in, 2) || !$past(fault_n_in, 3) || !$past(fault_n_in, 4))
    else $error("pin released with no fault");
  a_rearm_cause: assert property ($rose(pin_oe_out) |->
    $past(fault_n_in, 2) || $past(fault_n_in, 3) || $past(fault_n_in, 4))
    else $error("pin driven while fault low");
  a_trip_hold: assert property (!pin_oe_out && !fault_n_in && !$past(fault_n_in)
    && !$past(fault_n_in, 2)
    |=> !pin_oe_out)
    else $error("trip ended while fault low");
  a_rdata_stand: assert property (!rd_in |=> $stable(rdata_out))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_in && addr_in > 4'hA |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind ccp_pwm_channel ccp_pwm_props u_props (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .sleep_in(sleep_in),
  .fault_n_in(fault_n_in), .rdata_out(rdata_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .irq_out(irq_out));

// *** test/ccp_pwm_load.sv ***
// Purpose: load on the channel pin and external fault source
// Assumes: no pull on the pin line
// Notes: fault level follows the bench request one cycle later
`timescale 1ns/1ns
module ccp_pwm_load (
  input wire mclk_in,
  input wire pin_out,
  input wire pin_oe_out,
  input wire trip_in,
  output reg fault_n_out,
  output wire pin_level_out
);
  initial begin
    fault_n_out = 1'b1;
  end
  always @(posedge mclk_in) begin
    fault_n_out <= ~trip_in;
  end
  // released line floats, so show the inverse rather than a stale level
  assign pin_level_out = pin_oe_out ? pin_out : ~pin_out;
endmodule

// *** test/compare_channel_pwm_tb.sv ***
// Purpose: self-checking bench for ccp_pwm_channel
// Assumes: 25 MHz clock, reset held 10 cycles
// Notes: high time is counted over whole periods, so phase does not matter
`timescale 1ns/1ns
`include "ccp_pwm_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module compare_channel_pwm_tb;
  reg mclk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [3:0] addr_in = 4'h0;
  reg [15:0] wdata_in = 16'h0000;
  reg wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0, idle_in = 1'b0, trip = 1'b0;
  reg [15:0] lfsr = 16'h005D;
  reg [15:0] rd;
  wire [15:0] rdata_out;
  wire pin_out, pin_oe_out, irq_out, fault_n, pin_lvl;
  int checks = 0, num_errors = 0;
  always #20 mclk_in = ~mclk_in;
  ccp_pwm_channel dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sleep_in(sleep_in),
    .idle_in(idle_in), .fault_n_in(fault_n), .rdata_out(rdata_out), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .irq_out(irq_out));
  ccp_pwm_load load (.mclk_in(mclk_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .trip_in(trip), .fault_n_out(fault_n), .pin_level_out(pin_lvl));
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task conclude;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // extra cycle after each strobe keeps one assignment per signal per step
  task wr(input [3:0] a, input [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task rg(input [3:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 rd = rdata_out;
    @(posedge mclk_in);
  endtask
  task hi(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk_in);
      #1 c += pin_lvl;
    end
  endtask
  initial begin
    int p, d, c, b;
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    for (int a = 0; a < 16; a++) begin
      rg(4'(a));
      `CHK(rd, 16'h0000)
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      p = 2 + lfsr[2:0];
      d = (i == 0) ? 0 : (i == 1) ? p + 1 : lfsr[7:4] % (p + 3);
      b = i % 2 * 3;
      wr(4'(4 + b), 16'(p));
      wr(4'h2, 16'(d));
      wr(4'h0, b ? 16'h000E : 16'h0006);
      wr(4'(5 + b), 16'h0000);
      wr(4'(3 + b), 16'h8000);
      wr(4'h9, 16'h0007);
      sleep_in <= 1'b1;
      cyc(1 + lfsr[11:8]);
      sleep_in <= 1'b0;
      idle_in <= lfsr[12];
      cyc(2 * p + 2);
      hi(4 * p + 4, c);
      idle_in <= 1'b0;
      `CHK(c, 4 * (d == 0 ? 0 : d > p ? p + 1 : d))
      wr(4'h1, 16'hFFFF);
      rg(4'h1);
      `CHK(rd, 16'(d))
      rg(4'h9);
      `CHK(rd[b ? 2 : 1], 1'b1)
      `CHK(rd[0], 1'b0)
      $display("duty test %0d done", i);
    end
    wr(4'hA, 16'h0004);
    cyc(2);
    `CHK(irq_out, 1'b1)
    wr(4'h6, 16'h0000);
    wr(4'h3, 16'h0000);
    cyc(20);
    `CHK(irq_out, 1'b1)
    wr(4'h9, 16'h0007);
    cyc(2);
    `CHK(irq_out, 1'b0)
    $display("irq test done");
    wr(4'h2, 16'h0002);
    wr(4'h0, 16'h0007);
    wr(4'h3, 16'h8000);
    trip <= 1'b1;
    for (c = 0; c < 10 && pin_oe_out !== 1'b0; c++) cyc(1);
    `CHK(pin_oe_out, 1'b0)
    if (pin_oe_out !== 1'b0) conclude();
    rg(4'h0);
    `CHK(rd[4], 1'b1)
    wr(4'h0, 16'h0007);
    trip <= 1'b0;
    cyc(10);
    `CHK(pin_oe_out, 1'b0)
    wr(4'h0, 16'h0007);
    cyc(6);
    `CHK(pin_oe_out, 1'b1)
    rg(4'h0);
    `CHK(rd[4], 1'b0)
    $display("fault test done");
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0001);
    wr(4'h9, 16'h0007);
    cyc(40);
    rg(4'h9);
    `CHK(rd[0], 1'b1)
    wr(4'h0, 16'h0002);
    cyc(40);
    `CHK(pin_out, 1'b1)
    $display("compare test done");
    conclude();
  end
endmodule
